/* common/adcprr_pkg.sv */
/*
 * Shared types and constants of the parallel result readout block.
 * Assumes a single 100 MHz clock; all timing counts derive from it.
 */
package adcprr_pkg;

	// ----------------------------------------------------------------
	// Widths and timing
	// ----------------------------------------------------------------
	localparam int RES_W          = 14;            // Result width in bits
	localparam int BYTE_W         = 8;             // Narrow output width
	localparam int CLK_PERIOD_PS  = 10000;         // 100 MHz
	localparam int CONV_MAX_PS    = 4700000;       // Longest conversion, 4.7 us
	// Longest time rounds down to whole cycles
	localparam int CONV_CYCLES    = CONV_MAX_PS / CLK_PERIOD_PS;
	localparam int OUT_DELAY_PS   = 10000;         // Select-to-data delay
	// Least time rounds up, never below one cycle
	localparam int OUT_DELAY_CYC  = (OUT_DELAY_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int CNT_W          = 10;
	localparam logic [RES_W-1:0] RESULT_RST = 14'h0000;
	localparam logic [RES_W-1:0] SAR_MSB    = 14'h2000;

	// ----------------------------------------------------------------
	// Phase machine, Gray coded along the usual path
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		ADCPRR_IDLE    = 3'b000,
		ADCPRR_ACQUIRE = 3'b001,
		ADCPRR_CONVERT = 3'b011,
		ADCPRR_DONE    = 3'b010,
		ADCPRR_READ    = 3'b110
	} adcprr_phase_t;

	// Host-side parallel port inputs
	typedef struct packed {
		logic select_n;
		logic read_conv;
		logic high_byte_sel;
	} adcprr_host_t;

	// Result bus pins (output plus enable)
	typedef struct packed {
		logic [RES_W-1:0] data;
		logic             oe;
	} adcprr_bus_t;

endpackage

/* design/adcprr_sar.sv */
/*
 * Successive-approximation engine: one bit decided per step, MSB first.
 * Assumes the sampled analog value arrives as a digital code on sample_in.
 */
`timescale 1ns/1ps
`default_nettype none

module adcprr_sar
	import adcprr_pkg::*;
#(
	parameter int STEP_CYCLES = 4
) (
	// Clock and reset
	input  wire logic             clk_in,
	input  wire logic             rstn_in,
	input  wire logic             ce_in,
	// Control
	input  wire logic             start_in,
	input  wire logic [RES_W-1:0] sample_in,
	// Result
	output logic                  done_out,
	output logic [RES_W-1:0]      result_out
);

	initial begin
		if (STEP_CYCLES < 1 || STEP_CYCLES * RES_W > CONV_CYCLES)
			$error("adcprr_sar: conversion would exceed its time limit");
	end

	typedef struct packed {
		logic [RES_W-1:0] trial;
		logic [RES_W-1:0] bitm;
		logic [RES_W-1:0] held;
		logic [CNT_W-1:0] step;
		logic             busy;
		logic             done;
	} adcprr_sar_t;

	adcprr_sar_t s_reg;
	adcprr_sar_t s_next;

	// ----------------------------------------------------------------
	// Binary search; the trial code is plain unsigned binary
	// ----------------------------------------------------------------
	always_comb begin
		s_next      = s_reg;
		s_next.done = 1'b0;
		if (start_in) begin
			s_next.held  = sample_in;                 // Freeze the sample
			s_next.trial = RESULT_RST;
			s_next.bitm  = SAR_MSB;
			s_next.step  = '0;
			s_next.busy  = 1'b1;
		end else if (s_reg.busy) begin
			if (s_reg.step == CNT_W'(STEP_CYCLES - 1)) begin
				s_next.step = '0;
				// Keep the bit while trial stays at or below the sample
				if ((s_reg.trial | s_reg.bitm) <= s_reg.held)
					s_next.trial = s_reg.trial | s_reg.bitm;
				s_next.bitm = s_reg.bitm >> 1;
				if (s_reg.bitm[0]) begin
					s_next.busy = 1'b0;
					s_next.done = 1'b1;
				end
			end else begin
				s_next.step = s_reg.step + 1'b1;
			end
		end
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			s_reg <= '0;
		end else if (ce_in) begin
			s_reg <= s_next;
		end
	end

	assign done_out   = s_reg.done;
	assign result_out = s_reg.trial;

endmodule

`default_nettype wire

/* design/adcprr_top.sv */
/*
 * Control and readout of a 14-bit converter behind a parallel host port.
 * Assumes the host pins are synchronous to clk_in; the bus wire is
 * resolved outside from result_oe_out.
 */
`timescale 1ns/1ps
`default_nettype none

// Function
// - Done output falls when result is valid
// - Bus released during acquisition and conversion
// - Third select fall, read high, drives result
// - Select rising releases the result bus
// - Idle after read until next select fall
// - Wide variant 14 bits, narrow byte-wide
// - High-byte select low gives LSB, high MSB
// - Reset with select high, next fall acquires
// - Result coded as straight unsigned binary
// - Fall with read low starts acquisition only
// - Second fall freezes sample, starts converting
// - Read level at second fall picks power-down
// - Conversion finishes within 4.7 us
module adcprr_top
	import adcprr_pkg::*;
#(
	parameter int  STEP_CYCLES = 4,
	parameter bit  WIDE        = 1'b1
) (
	// Clock, reset, enable
	input  wire logic             clk_in,
	input  wire logic             rstn_in,
	input  wire logic             ce_in,
	// Host port
	input  wire logic             select_n_in,
	input  wire logic             read_conv_in,
	input  wire logic             high_byte_sel_in,
	input  wire logic             dev_reset_in,
	// Sampled analog value as a code
	input  wire logic [RES_W-1:0] analog_in,
	// Result bus and status
	output logic [RES_W-1:0]      result_bus_out,
	output logic                  result_oe_out,
	output logic                  conv_done_n_out,
	output logic                  shutdown_out,
	output logic                  acquiring_out
);

	initial begin
		if (OUT_DELAY_CYC < 1 || OUT_DELAY_CYC >= (1 << CNT_W))
			$error("adcprr_top: output delay count out of range");
	end

	typedef struct packed {
		adcprr_phase_t    phase;
		logic             sel_prev;
		logic             shut;
		logic             done_n;
		logic             oe;
		logic             acq;
		logic [CNT_W-1:0] dly;
		logic [RES_W-1:0] result;
		logic [RES_W-1:0] bus;
	} adcprr_state_t;

	adcprr_state_t st_reg;
	adcprr_state_t st_next;
	adcprr_host_t  host;
	logic          sel_fall;
	logic          sel_rise;
	logic          sar_start;
	logic          sar_done;
	logic [RES_W-1:0] sar_result;

	assign host     = '{select_n: select_n_in, read_conv: read_conv_in,
		high_byte_sel: high_byte_sel_in};
	assign sel_fall = st_reg.sel_prev & ~host.select_n;
	assign sel_rise = ~st_reg.sel_prev & host.select_n;

	// ----------------------------------------------------------------
	// Converter core
	// ----------------------------------------------------------------
	adcprr_sar #(
		.STEP_CYCLES (STEP_CYCLES)
	) u_sar (
		.clk_in     (clk_in),
		.rstn_in    (rstn_in),
		.ce_in      (ce_in),
		.start_in   (sar_start),
		.sample_in  (analog_in),
		.done_out   (sar_done),
		.result_out (sar_result)
	);

	// Second select fall during acquisition holds the sample
	assign sar_start = ce_in && st_reg.phase == ADCPRR_ACQUIRE && sel_fall;

	// ----------------------------------------------------------------
	// Phase sequencing
	// ----------------------------------------------------------------
	always_comb begin
		st_next          = st_reg;
		st_next.sel_prev = host.select_n;
		case (st_reg.phase)
			ADCPRR_IDLE: begin
				// Start only with read low; a read-high fall is ignored
				if (sel_fall && !host.read_conv) begin
					st_next.phase  = ADCPRR_ACQUIRE;
					st_next.acq    = 1'b1;
					st_next.shut   = 1'b0;
					st_next.done_n = 1'b1;
				end
			end
			ADCPRR_ACQUIRE: begin
				if (sel_fall) begin
					st_next.phase = ADCPRR_CONVERT;
					st_next.acq   = 1'b0;
					st_next.shut  = host.read_conv;
				end
			end
			ADCPRR_CONVERT: begin
				st_next.oe = 1'b0;
				if (sar_done) begin
					st_next.result = sar_result;
					st_next.done_n = 1'b0;
					st_next.phase  = ADCPRR_DONE;
				end
			end
			ADCPRR_DONE: begin
				if (sel_fall && host.read_conv) begin
					st_next.phase = ADCPRR_READ;
					st_next.dly   = CNT_W'(OUT_DELAY_CYC);
				end else if (sel_fall) begin
					// A convert request starts a fresh cycle
					st_next.phase  = ADCPRR_ACQUIRE;
					st_next.acq    = 1'b1;
					st_next.shut   = 1'b0;
					st_next.done_n = 1'b1;
				end
			end
			ADCPRR_READ: begin
				if (st_reg.dly > 1)
					st_next.dly = st_reg.dly - 1'b1;
				else if (!host.select_n)
					st_next.oe = 1'b1;
				// Byte steering follows the select live while reading
				if (WIDE)
					st_next.bus = st_reg.result;
				else if (host.high_byte_sel)
					st_next.bus = RES_W'(st_reg.result[RES_W-1:BYTE_W]);
				else
					st_next.bus = RES_W'(st_reg.result[BYTE_W-1:0]);
				if (sel_rise) begin
					st_next.oe    = 1'b0;
					st_next.phase = ADCPRR_IDLE;
				end
			end
			default: st_next.phase = ADCPRR_IDLE;
		endcase
		// Reset with select high returns to idle, no dummy cycle needed
		if (dev_reset_in && host.select_n) begin
			st_next.phase  = ADCPRR_IDLE;
			st_next.oe     = 1'b0;
			st_next.acq    = 1'b0;
			st_next.done_n = 1'b1;
		end
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			st_reg          <= '0;
			st_reg.phase    <= ADCPRR_IDLE;
			st_reg.sel_prev <= 1'b1;
			st_reg.done_n   <= 1'b1;
		end else if (ce_in) begin
			st_reg <= st_next;
		end
	end

	// Outputs straight from flip-flops
	assign result_bus_out  = st_reg.bus;
	assign result_oe_out   = st_reg.oe;
	assign conv_done_n_out = st_reg.done_n;
	assign shutdown_out    = st_reg.shut;
	assign acquiring_out   = st_reg.acq;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	bus_quiet_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
		(st_reg.phase == ADCPRR_ACQUIRE || st_reg.phase == ADCPRR_CONVERT) |-> !result_oe_out)
		else $error("result bus driven outside read");
	done_fall_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
		$fell(conv_done_n_out) |-> st_reg.phase == ADCPRR_DONE)
		else $error("done fell without result");
	conv_time_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
		(ce_in && sar_start) |-> ##[1:470] (conv_done_n_out == 1'b0))
		else $error("conversion too long");
	read_drive_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
		(ce_in && st_reg.phase == ADCPRR_DONE && sel_fall && host.read_conv
		&& !dev_reset_in) ##1 (ce_in && !host.select_n)[*3] |-> result_oe_out)
		else $error("read did not drive bus");
	bus_release_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
		(ce_in && sel_rise) |=> !result_oe_out)
		else $error("bus not released");
	byte_pick_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
		(!WIDE && result_oe_out && $past(ce_in) && !$past(high_byte_sel_in))
		|-> result_bus_out == RES_W'(st_reg.result[BYTE_W-1:0]))
		else $error("wrong byte on bus");
	mode_pick_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
		(ce_in && sar_start && !dev_reset_in) |=> shutdown_out == $past(read_conv_in))
		else $error("power mode not latched");
	done_rise_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
		$rose(acquiring_out) |-> conv_done_n_out)
		else $error("done still low in acquisition");
	reset_idle_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
		(ce_in && dev_reset_in && select_n_in) |=> st_reg.phase == ADCPRR_IDLE)
		else $error("reset did not idle");
	no_start_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
		(ce_in && st_reg.phase == ADCPRR_IDLE && sel_fall && read_conv_in)
		|=> !acquiring_out)
		else $error("read-high fall started acquisition");

endmodule

`default_nettype wire

/* bench/adcprr_host.sv */
/*
 * Host model: drives select, read/convert, byte choice, reset and code.
 * Assumes its tasks are called just after a rising edge of clk_in.
 */
`timescale 1ns/1ps
`default_nettype none

module adcprr_host
	import adcprr_pkg::*;
(
	// Clock
	input  wire logic        clk_in,
	// Host port
	output logic             select_n_out,
	output logic             read_conv_out,
	output logic             high_byte_sel_out,
	output logic             dev_reset_out,
	// Sampled input code
	output logic [RES_W-1:0] analog_out
);
	// Idle levels from time zero
	initial begin
		select_n_out = 1'b1;
		read_conv_out = 1'b0;
		high_byte_sel_out = 1'b0;
		dev_reset_out = 1'b0;
		analog_out = '0;
	end

	// Change pins 1 ns after the edge so sampling never races
	task automatic drive(input logic sel_n, input logic rc);
		@(posedge clk_in) #1;
		read_conv_out = rc;
		select_n_out = sel_n;
	endtask

	// Byte choice for the narrow bus
	task automatic byte_hi(input logic v);
		high_byte_sel_out = v;
	endtask

	// Acquire, then convert with the chosen power-down mode
	task automatic conv(input logic mode, input logic [RES_W-1:0] code);
		analog_out = code;
		drive(1'b0, 1'b0);
		drive(1'b1, 1'b0);
		drive(1'b0, mode);
		drive(1'b1, mode);
		analog_out = ~code;
	endtask

	// Reset pulse of one cycle; select is left at whatever level it has
	task automatic reset_pulse();
		@(posedge clk_in) #1;
		dev_reset_out = 1'b1;
		@(posedge clk_in) #1;
		dev_reset_out = 1'b0;
	endtask
endmodule

`default_nettype wire

/* bench/tb_adc_parallel_result_readout.sv */
/*
 * Bench: wide and narrow instances share one host model.
 * Assumes the package and host model are compiled before it.
 */
`timescale 1ns/1ps
`default_nettype none

module tb_adc_parallel_result_readout
	import adcprr_pkg::*;
;
	logic             clk_in = 1'b0;
	logic             rstn_in = 1'b0;
	logic             ce = 1'b1;
	logic             sel_n, rc, hbs, dres;
	logic [RES_W-1:0] code, bus_w, bus_n;
	logic             oe_w, oe_n, done_w, done_n, shd, acq;
	int               fail_count = 0;
	int               samples_checked = 0;

	// 100 MHz clock
	always #5 clk_in = ~clk_in;

	adcprr_host i_adcprr_host (.clk_in(clk_in), .select_n_out(sel_n), .read_conv_out(rc),
		.high_byte_sel_out(hbs), .dev_reset_out(dres), .analog_out(code));

	// Wide and narrow variants see identical host traffic
	adcprr_top #(.WIDE(1'b1)) i_adcprr_top (.clk_in(clk_in), .rstn_in(rstn_in), .ce_in(ce),
		.select_n_in(sel_n), .read_conv_in(rc), .high_byte_sel_in(hbs), .dev_reset_in(dres),
		.analog_in(code), .result_bus_out(bus_w), .result_oe_out(oe_w),
		.conv_done_n_out(done_w), .shutdown_out(shd), .acquiring_out(acq));
	adcprr_top #(.WIDE(1'b0)) i_adcprr_top_n (.clk_in(clk_in), .rstn_in(rstn_in), .ce_in(ce),
		.select_n_in(sel_n), .read_conv_in(rc), .high_byte_sel_in(hbs), .dev_reset_in(dres),
		.analog_in(code), .result_bus_out(bus_n), .result_oe_out(oe_n),
		.conv_done_n_out(done_n), .shutdown_out(), .acquiring_out());

	// Compare and count
	task automatic check(input logic [RES_W-1:0] seen, input logic [RES_W-1:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value at %0t ns: got %h want %h", $time, seen, exp);
		end
	endtask

	task automatic chk1(input logic seen, input logic exp);
		check({13'h0000, seen}, {13'h0000, exp});
	endtask

	// Bounded wait: a slow conversion shows as a mismatch
	task automatic wait_done();
		int n;
		n = 0;
		while (done_w !== 1'b0 && n < CONV_CYCLES) begin
			@(posedge clk_in);
			#1;
			n++;
		end
		chk1(done_w, 1'b0);
		chk1(done_n, 1'b0);
	endtask

	// Read cycle: both bytes on the narrow bus, then release
	task automatic read_out(input logic [RES_W-1:0] exp);
		i_adcprr_host.byte_hi(1'b0);
		i_adcprr_host.drive(1'b0, 1'b1);
		repeat (3) @(posedge clk_in);
		#1;
		chk1(oe_w, 1'b1);
		chk1(oe_n, 1'b1);
		check(bus_w, exp);
		check(bus_n, {6'h00, exp[7:0]});
		i_adcprr_host.byte_hi(1'b1);
		repeat (2) @(posedge clk_in);
		#1;
		check(bus_n, {8'h00, exp[13:8]});
		i_adcprr_host.drive(1'b1, 1'b1);
		repeat (2) @(posedge clk_in);
		#1;
		chk1(oe_w, 1'b0);
		chk1(oe_n, 1'b0);
	endtask

	// Full cycle; input code changes after sampling to catch late capture
	task automatic convert(input logic mode, input logic [RES_W-1:0] val);
		i_adcprr_host.conv(mode, val);
		chk1(shd, mode);
		chk1(acq, 1'b0);
		chk1(oe_w, 1'b0);
		chk1(done_w, 1'b1);
		wait_done();
		read_out(val);
	endtask

	task automatic t_standby();
		convert(1'b0, 14'h2a5c);
		$display("test standby done");
	endtask

	// Shutdown at full scale, then a read-level fall while idle
	task automatic t_shutdown();
		convert(1'b1, 14'h3fff);
		i_adcprr_host.drive(1'b0, 1'b1);
		repeat (3) @(posedge clk_in);
		#1;
		chk1(acq, 1'b0);
		chk1(oe_w, 1'b0);
		i_adcprr_host.drive(1'b1, 1'b1);
		$display("test shutdown done");
	endtask

	// Reset after an unread result, then a clean cycle with no dummy
	task automatic t_reset();
		i_adcprr_host.conv(1'b0, 14'h0000);
		wait_done();
		i_adcprr_host.reset_pulse();
		@(posedge clk_in);
		#1;
		chk1(done_w, 1'b1);
		convert(1'b0, 14'h1555);
		$display("test reset done");
	endtask

	// Enable low across a select fall, a reset refused while select is low,
	// then a convert fall that abandons the unread result
	task automatic t_freeze();
		i_adcprr_host.drive(1'b0, 1'b0);
		i_adcprr_host.drive(1'b1, 1'b0);
		chk1(acq, 1'b1);
		@(posedge clk_in);
		#1;
		ce = 1'b0;
		i_adcprr_host.drive(1'b0, 1'b1);
		repeat (3) @(posedge clk_in);
		#1;
		// Frozen: the fall is held back, not lost
		chk1(acq, 1'b1);
		chk1(shd, 1'b0);
		ce = 1'b1;
		@(posedge clk_in);
		#1;
		chk1(acq, 1'b0);
		chk1(shd, 1'b1);
		// A reset with select low must leave the conversion running
		i_adcprr_host.reset_pulse();
		i_adcprr_host.drive(1'b1, 1'b1);
		wait_done();
		i_adcprr_host.drive(1'b0, 1'b0);
		i_adcprr_host.drive(1'b1, 1'b0);
		chk1(acq, 1'b1);
		chk1(done_w, 1'b1);
		i_adcprr_host.drive(1'b0, 1'b0);
		i_adcprr_host.drive(1'b1, 1'b0);
		wait_done();
		// Input code left by the host after the previous cycle
		read_out(14'h2aaa);
		$display("test freeze done");
	endtask

	task automatic final_report();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// Main sequence after 16 cycles of reset
	initial begin
		repeat (16) @(posedge clk_in);
		#1;
		rstn_in = 1'b1;
		t_standby();
		t_shutdown();
		t_reset();
		t_freeze();
		final_report();
	end

	// Watchdog: the run needs well under 5000 cycles
	initial begin
		#50000;
		fail_count++;
		final_report();
	end
endmodule

`default_nettype wire
